/* inc/serdes_seq_pkg.sv */
// Constants shared by the transceiver channel model.
// Assumes one clock (parallel clock, 250 MHz) and synchronous active-high reset.
// What this block does
// - XAUI bonds channels; each reports own lock.
// - PLL acquires lock after reset, raises lock.
// - Busy pulses at power-up and on reconfiguration.
// - Each channel's data lock rises independently.
// - Data select switches every CDR to data lock.
// - Non-bonded channels have independent resets and flags.
// - XAUI bonds receive and transmit channels together.
// - Select encoding: 10 reference, x1 data, 00 auto.
// - Busy low first cycle, then high until done.
// - Lock flag high in data mode, low otherwise.
package serdes_seq_pkg;
   // Clock period in picoseconds
   localparam int CLK_PERIOD_PS = 4000;
   // Default PLL lock acquisition time in ns
   localparam int PLL_LOCK_NS = 200;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS * 1000) / CLK_PERIOD_PS;
   // Default offset cancellation duration in ns
   localparam int OFFSET_CANCEL_NS = 400;
   localparam int OFFSET_CANCEL_CYCLES = (OFFSET_CANCEL_NS * 1000) / CLK_PERIOD_PS;
   // Default CDR data-lock acquisition time in ns
   localparam int CDR_LOCK_NS = 100;
   localparam int CDR_LOCK_CYCLES = (CDR_LOCK_NS * 1000) / CLK_PERIOD_PS;
   // Busy pulse for a reconfiguration access lasts one cycle more than this count
   localparam int RECONF_BUSY_CYCLES = 8;
   // Counter width
   localparam int CNT_W = 16;
   // Lock-select encodings
   localparam logic [1:0] SEL_AUTO = 2'h0;
   localparam logic [1:0] SEL_REF  = 2'h2;
   // CDR states
   typedef enum logic [1:0]
   {
      CDR_RESET = 2'b00,
      CDR_REF   = 2'b01,
      CDR_DATA  = 2'b10
   } cdr_state_type;
endpackage

/* rtl/cdr_channel.sv */
// One receive channel CDR model with data-lock flag.
// Assumes select and reset inputs already synchronised by the parent.
`timescale 1ns/10ps
module cdr_channel
#(
   parameter int LOCK_CYCLES = serdes_seq_pkg::CDR_LOCK_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clkEn,
   input  wire logic cdrReset,      // Analog reset of this CDR
   input  wire logic lockToRef,     // Manual reference select
   input  wire logic lockToData,    // Manual data select
   input  wire logic dataPresent,   // Serial data seen at receiver
   output logic      freqLocked     // High in lock-to-data mode
);
   //------------------------------------------------------------
   // CDR lock mode state
   //------------------------------------------------------------
   serdes_seq_pkg::cdr_state_type state_reg; // Current CDR mode
   logic [serdes_seq_pkg::CNT_W-1:0] cnt_reg; // Acquisition timer

   // Mode state; auto mode moves to data once reference is held long enough
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= serdes_seq_pkg::CDR_RESET;
         cnt_reg   <= '0;
      end
      else if (clkEn)
      begin
         case (state_reg)
            serdes_seq_pkg::CDR_RESET:
            begin
               cnt_reg <= '0;
               if (!cdrReset)
                  state_reg <= serdes_seq_pkg::CDR_REF;
            end
            serdes_seq_pkg::CDR_REF:
            begin
               if (cdrReset)
                  state_reg <= serdes_seq_pkg::CDR_RESET;
               // x1 data, 10 reference, 00 auto
               else if (lockToData)
                  state_reg <= serdes_seq_pkg::CDR_DATA;
               else if (!lockToRef && dataPresent)
               begin
                  if (cnt_reg >= LOCK_CYCLES[serdes_seq_pkg::CNT_W-1:0])
                     state_reg <= serdes_seq_pkg::CDR_DATA;
                  else
                     cnt_reg <= cnt_reg + 1'b1;
               end
            end
            serdes_seq_pkg::CDR_DATA:
            begin
               // Losing data in auto mode falls back to reference
               if (cdrReset)
                  state_reg <= serdes_seq_pkg::CDR_RESET;
               else if (!lockToData && (lockToRef || !dataPresent))
               begin
                  state_reg <= serdes_seq_pkg::CDR_REF;
                  cnt_reg   <= '0;
               end
            end
            default:
               state_reg <= serdes_seq_pkg::CDR_RESET;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         freqLocked <= 1'b0;
      else if (clkEn)
         freqLocked <= (state_reg == serdes_seq_pkg::CDR_DATA) && !cdrReset;
   end
endmodule

/* rtl/serdes_channel_reset_sequencer.sv */
// Device side of a transceiver group: PLL, busy source, per-channel CDRs.
// Assumes control inputs come from an outside controller and are asynchronous.
`timescale 1ns/10ps
module serdes_channel_reset_sequencer
#(
   parameter int CHANNELS      = 4,
   parameter int PLL_CYCLES    = serdes_seq_pkg::PLL_LOCK_CYCLES,
   parameter int OFFSET_CYCLES = serdes_seq_pkg::OFFSET_CANCEL_CYCLES,
   parameter int CDR_CYCLES    = serdes_seq_pkg::CDR_LOCK_CYCLES
)
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   input  wire logic                bondedMode,     // XAUI style bonding
   input  wire logic                pllReset,       // Transmit PLL reset
   input  wire logic [CHANNELS-1:0] txPcsReset,     // Transmit digital reset
   input  wire logic [CHANNELS-1:0] rxPcsReset,     // Receive digital reset
   input  wire logic [CHANNELS-1:0] rxCdrReset,     // Receive analog reset
   input  wire logic [CHANNELS-1:0] lockToRef,      // Reference select
   input  wire logic [CHANNELS-1:0] lockToData,     // Data select
   input  wire logic [CHANNELS-1:0] dataPresent,    // Serial data present
   input  wire logic                reconfAccess,   // Reconfiguration access pulse
   output logic                     pllLocked,      // PLL lock flag
   output logic                     busy,           // Reconfiguration busy
   output logic [CHANNELS-1:0]      freqLocked,     // Per-channel data lock
   output logic [CHANNELS-1:0]      txReady,        // Transmit PCS running
   output logic [CHANNELS-1:0]      rxReady         // Receive PCS running
);
   //------------------------------------------------------------
   // Input synchronisers
   //------------------------------------------------------------
   localparam int SW = 5 * CHANNELS + 2;
   logic [SW-1:0] syncA_reg;   // First stage, read only by second
   logic [SW-1:0] syncB_reg;   // Second stage, used by logic

   // Two flops on every asynchronous control input
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         syncA_reg <= '1;
         syncB_reg <= '1;
      end
      else if (clkEn)
      begin
         syncA_reg <= {pllReset, reconfAccess, txPcsReset, rxPcsReset,
                       rxCdrReset, lockToRef, lockToData};
         syncB_reg <= syncA_reg;
      end
   end

   logic                pllRstS;
   logic                accessS;
   logic [CHANNELS-1:0] txRstS;
   logic [CHANNELS-1:0] rxRstS;
   logic [CHANNELS-1:0] cdrRstS;
   logic [CHANNELS-1:0] refSelS;
   logic [CHANNELS-1:0] datSelS;
   assign {pllRstS, accessS, txRstS, rxRstS, cdrRstS, refSelS, datSelS} = syncB_reg;

   logic [CHANNELS-1:0] dataS1_reg; // Data-present first stage
   logic [CHANNELS-1:0] dataS2_reg; // Data-present second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dataS1_reg <= '0;
         dataS2_reg <= '0;
      end
      else if (clkEn)
      begin
         dataS1_reg <= dataPresent;
         dataS2_reg <= dataS1_reg;
      end
   end

   logic bondS1_reg; // Bonding select first stage
   logic bondS2_reg; // Bonding select second stage, used by logic

   // Bonding comes from outside the clock domain; syncing it keeps
   // a mode change from reaching some channels a cycle before others
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bondS1_reg <= 1'b0;
         bondS2_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         bondS1_reg <= bondedMode;
         bondS2_reg <= bondS1_reg;
      end
   end

   //------------------------------------------------------------
   // Transmit PLL
   //------------------------------------------------------------
   logic [serdes_seq_pkg::CNT_W-1:0] pllCnt_reg; // Lock acquisition timer

   // count from reset release, then raise lock
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pllCnt_reg <= '0;
         pllLocked  <= 1'b0;
      end
      else if (clkEn)
      begin
         if (pllRstS)
         begin
            pllCnt_reg <= '0;
            pllLocked  <= 1'b0;
         end
         else if (pllCnt_reg >= PLL_CYCLES[serdes_seq_pkg::CNT_W-1:0])
            pllLocked <= 1'b1;
         else
            pllCnt_reg <= pllCnt_reg + 1'b1;
      end
   end

   //------------------------------------------------------------
   // Busy: offset cancellation and reconfiguration accesses
   //------------------------------------------------------------
   logic                             firstDone_reg; // First cycle passed
   logic                             offsetDone_reg;// Cancellation over
   logic [serdes_seq_pkg::CNT_W-1:0] busyCnt_reg;   // Busy duration

   // low one cycle, then high until cancellation ends
   // later pulses only on reconfiguration access
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         firstDone_reg  <= 1'b0;
         offsetDone_reg <= 1'b0;
         busyCnt_reg    <= '0;
         busy           <= 1'b0;
      end
      else if (clkEn)
      begin
         firstDone_reg <= 1'b1;
         if (!firstDone_reg)
            busy <= 1'b0;
         else if (!offsetDone_reg)
         begin
            busy <= 1'b1;
            if (busyCnt_reg >= OFFSET_CYCLES[serdes_seq_pkg::CNT_W-1:0])
            begin
               offsetDone_reg <= 1'b1;
               busy           <= 1'b0;
               busyCnt_reg    <= '0;
            end
            else
               busyCnt_reg <= busyCnt_reg + 1'b1;
         end
         else if (busy)
         begin
            if (busyCnt_reg >= serdes_seq_pkg::RECONF_BUSY_CYCLES[serdes_seq_pkg::CNT_W-1:0])
            begin
               busy        <= 1'b0;
               busyCnt_reg <= '0;
            end
            else
               busyCnt_reg <= busyCnt_reg + 1'b1;
         end
         else if (accessS)
            busy <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // Bonding of selects and resets
   //------------------------------------------------------------
   logic [CHANNELS-1:0] chCdrRst;  // Effective CDR reset per channel
   logic [CHANNELS-1:0] chRef;     // Effective reference select
   logic [CHANNELS-1:0] chDat;     // Effective data select
   logic [CHANNELS-1:0] chTxRst;   // Effective transmit reset
   logic [CHANNELS-1:0] chRxRst;   // Effective receive reset

   // bonded group follows channel zero's controls
   // otherwise each channel uses its own
   always_comb
   begin
      if (bondS2_reg)
      begin
         chCdrRst = {CHANNELS{cdrRstS[0]}};
         chRef    = {CHANNELS{refSelS[0]}};
         chDat    = {CHANNELS{datSelS[0]}};
         chTxRst  = {CHANNELS{txRstS[0]}};
         chRxRst  = {CHANNELS{rxRstS[0]}};
      end
      else
      begin
         chCdrRst = cdrRstS;
         chRef    = refSelS;
         chDat    = datSelS;
         chTxRst  = txRstS;
         chRxRst  = rxRstS;
      end
   end

   //------------------------------------------------------------
   // Receive CDRs and PCS status
   //------------------------------------------------------------
   // one independent lock flag per receive channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1)
      begin : chan
         cdr_channel #(.LOCK_CYCLES(CDR_CYCLES)) cdr
         (
            .clk        (clk),
            .rst        (rst),
            .clkEn      (clkEn),
            .cdrReset   (chCdrRst[g]),
            .lockToRef  (chRef[g]),
            .lockToData (chDat[g]),
            .dataPresent(dataS2_reg[g]),
            .freqLocked (freqLocked[g])
         );
      end
   endgenerate

   // Transmit PCS runs only when its reset is low and the PLL is locked; receive PCS when its reset and CDR reset are low
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         txReady <= '0;
         rxReady <= '0;
      end
      else if (clkEn)
      begin
         txReady <= ~chTxRst & {CHANNELS{pllLocked}};
         rxReady <= ~chRxRst & ~chCdrRst;
      end
   end
endmodule

/* tb/serdes_seq_assertions.sv */
// Checker on the device ports: lock flags and busy timing.
// Assumes one clock; bound to the device at the foot of this file.
`timescale 1ns/10ps
module serdes_seq_assertions
#(
   parameter int CHANNELS      = 4,
   parameter int PLL_CYCLES    = 50,
   parameter int OFFSET_CYCLES = 100,
   parameter int CDR_CYCLES    = 25
)
(
   input wire logic                clk,
   input wire logic                rst,
   input wire logic                clkEn,
   input wire logic                bondedMode,
   input wire logic                pllReset,
   input wire logic [CHANNELS-1:0] rxCdrReset,
   input wire logic [CHANNELS-1:0] lockToRef,
   input wire logic [CHANNELS-1:0] lockToData,
   input wire logic [CHANNELS-1:0] dataPresent,
   input wire logic                reconfAccess,
   input wire logic                pllLocked,
   input wire logic                busy,
   input wire logic [CHANNELS-1:0] freqLocked
);
   localparam int LOCK_MAX = PLL_CYCLES + 8;
   localparam int AUTO_MAX = CDR_CYCLES + 8;
   wire logic [CHANNELS-1:0] autoOk = ~lockToRef & ~lockToData & ~rxCdrReset & dataPresent;
   wire logic [CHANNELS-1:0] dSel   = lockToData & ~rxCdrReset;
   logic [7:0] busyRun;    // Length of the current busy pulse
   logic [3:0] sinceCause; // Cycles since reset or an access, saturating
   // Counters let long spans be checked without long repetitions
   always_ff @(posedge clk)
      busyRun <= (rst || !busy) ? 8'h00 : busyRun + 8'h01;
   always_ff @(posedge clk)
      sinceCause <= (rst || reconfAccess) ? 4'h0 : sinceCause + {3'h0, sinceCause != 4'hf};
   default clocking cb @(posedge clk); endclocking
   // A frozen device keeps no timing, so checks pause with the enable
   default disable iff (rst || !clkEn);
   sequence busyStart;
      !busy ##[1:3] busy;
   endsequence
   a_busy_power_up: assert property ($fell(rst) |-> busyStart)
      else $error("busy did not start after reset");
   a_busy_max_len: assert property (busyRun <= OFFSET_CYCLES + 1)
      else $error("busy pulse too long");
   a_busy_has_cause: assert property ($rose(busy) |-> sinceCause < 4'h8)
      else $error("busy rose without a cause");
   a_busy_on_access: assert property (!busy[*4] ##1 (reconfAccess && !busy)[*2] |-> ##[0:4] busy)
      else $error("access gave no busy pulse");
   a_pll_held_low: assert property (pllReset[*5] |-> !pllLocked)
      else $error("pll locked while in reset");
   a_pll_lock_rise: assert property ($fell(pllReset) |-> ##[1:LOCK_MAX] (pllLocked || pllReset))
      else $error("pll lock late");
   a_bond_follows: assert property ((bondedMode && dSel[0])[*7] |-> &freqLocked)
      else $error("bonded group not locked together");
   for (genvar i = 0; i < CHANNELS; i++)
   begin : g_ch
      a_data_sel_lock: assert property ((!bondedMode && dSel[i])[*7] |-> freqLocked[i])
         else $error("data select gave no lock");
      a_ref_sel_low: assert property ((!bondedMode && lockToRef[i] && !lockToData[i])[*5] |-> !freqLocked[i])
         else $error("lock flag high in reference mode");
      a_auto_lock_soon: assert property ((!bondedMode && autoOk[i])[*2] |-> ##[0:AUTO_MAX] (freqLocked[i] || !autoOk[i]))
         else $error("automatic lock late");
   end
endmodule
bind serdes_channel_reset_sequencer serdes_seq_assertions #(.CHANNELS(CHANNELS),
   .PLL_CYCLES(PLL_CYCLES), .OFFSET_CYCLES(OFFSET_CYCLES), .CDR_CYCLES(CDR_CYCLES)) u_chk
   (.clk(clk), .rst(rst), .clkEn(clkEn), .bondedMode(bondedMode), .pllReset(pllReset),
   .rxCdrReset(rxCdrReset),
   .lockToRef(lockToRef), .lockToData(lockToData), .dataPresent(dataPresent),
   .reconfAccess(reconfAccess), .pllLocked(pllLocked), .busy(busy), .freqLocked(freqLocked));

/* tb/serdes_reset_ctrl.sv */
// Behavioural controller that runs the group reset sequence.
// Assumes the bench raises start; drives at falling edges.
`timescale 1ns/10ps
module serdes_reset_ctrl
#(
   parameter int CHANNELS = 4,
   parameter int HOLD     = 250, // One microsecond at 4 ns
   parameter int SETTLE   = 6    // Stand-in for the lock settling waits
)
(
   input  wire logic                clk,
   input  wire logic                start,
   input  wire logic                manual,
   input  wire logic                pllLocked,
   input  wire logic                busy,
   input  wire logic [CHANNELS-1:0] freqLocked,
   output logic                     pllReset,
   output logic [CHANNELS-1:0]      txPcsReset,
   output logic [CHANNELS-1:0]      rxPcsReset,
   output logic [CHANNELS-1:0]      rxCdrReset,
   output logic [CHANNELS-1:0]      lockToRef,
   output logic [CHANNELS-1:0]      lockToData,
   output logic                     done
);
   task automatic hold_all();
      pllReset = 1'b1;
      txPcsReset = '1;
      rxPcsReset = '1;
      rxCdrReset = '1;
      lockToRef = {CHANNELS{manual === 1'b1}};
      lockToData = '0;
      done = 1'b0;
   endtask
   initial
      hold_all();
   // counted waits; bounded so a dead device cannot hang it
   always @(posedge start)
   begin
      hold_all();
      repeat (HOLD) @(negedge clk);
      pllReset = 1'b0;
      for (int k = 0; k < 200 && !pllLocked; k++) @(negedge clk);
      txPcsReset = '0;
      for (int k = 0; k < 400 && busy; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      rxCdrReset = '0;
      repeat (SETTLE) @(negedge clk);
      if (manual)
      begin
         lockToRef = '0;
         lockToData = '1;
      end
      for (int k = 0; k < 100 && !(&freqLocked); k++) @(negedge clk);
      repeat (SETTLE) @(negedge clk);
      rxPcsReset = '0;
      done = 1'b1;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench: the controller model resets the device per mode.
// Assumes package, device, checker and controller model compiled first.
`timescale 1ns/10ps
module testbench;
   localparam int CH   = 4;
   localparam int OFFS = 20;
   typedef struct packed {logic b; logic m; logic [3:0] dp; logic [3:0] fl;} row_type;
   // Mode inputs beside the lock flags they should give
   row_type       rows [4] = '{'{1'b1, 1'b1, 4'hf, 4'hf}, '{1'b1, 1'b0, 4'hf, 4'hf},
                               '{1'b0, 1'b1, 4'hf, 4'hf}, '{1'b0, 1'b0, 4'h5, 4'h5}};
   logic          clk, rst, clkEn, bondedMode, reconfAccess, start, manual, done;
   logic          pllReset, pllLocked, busy;
   logic [CH-1:0] dataPresent, txPcsReset, rxPcsReset, rxCdrReset, lockToRef, lockToData;
   logic [CH-1:0] freqLocked, txReady, rxReady;
   int            bad_count, num_checks, busyHigh;
   serdes_channel_reset_sequencer #(.CHANNELS(CH), .PLL_CYCLES(5), .OFFSET_CYCLES(OFFS),
      .CDR_CYCLES(5)) u_serdes_channel_reset_sequencer (.clk(clk), .rst(rst), .clkEn(clkEn),
      .bondedMode(bondedMode), .pllReset(pllReset), .txPcsReset(txPcsReset),
      .rxPcsReset(rxPcsReset), .rxCdrReset(rxCdrReset), .lockToRef(lockToRef),
      .lockToData(lockToData), .dataPresent(dataPresent), .reconfAccess(reconfAccess),
      .pllLocked(pllLocked), .busy(busy), .freqLocked(freqLocked), .txReady(txReady),
      .rxReady(rxReady));
   serdes_reset_ctrl #(.CHANNELS(CH)) u_serdes_reset_ctrl (.clk(clk), .start(start),
      .manual(manual), .pllLocked(pllLocked), .busy(busy), .freqLocked(freqLocked),
      .pllReset(pllReset), .txPcsReset(txPcsReset), .rxPcsReset(rxPcsReset),
      .rxCdrReset(rxCdrReset), .lockToRef(lockToRef), .lockToData(lockToData), .done(done));
   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Busy cycles seen; cleared only while busy is low
   always @(negedge clk)
      busyHigh += (busy === 1'b1);
   // Watchdog: the whole run needs about 1400 cycles
   initial
   begin
      repeat (20000) @(negedge clk);
      bad_count++;
      conclude();
   end
   initial
   begin
      {bad_count, num_checks, busyHigh, start, reconfAccess} = '0;
      {rst, clkEn, bondedMode, manual} = 4'hf;
      dataPresent = '1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i])
      begin
         {bondedMode, manual, dataPresent} = {rows[i].b, rows[i].m, rows[i].dp};
         start = 1'b1;
         repeat (20) @(negedge clk);
         start = 1'b0;
         chk("pllLocked", 4'h0, {3'h0, pllLocked});
         for (int k = 0; k < 1000 && !done; k++) @(negedge clk);
         repeat (4) @(negedge clk);
         chk("pllLocked", 4'h1, {3'h0, pllLocked});
         chk("txReady", 4'hf, txReady);
         chk("rxReady", 4'hf, rxReady);
         chk("freqLocked", rows[i].fl, freqLocked);
      end
      // Second reset in mid-run: outputs clear, offset pulse replays
      rst = 1'b1;
      repeat (4) @(negedge clk);
      chk("rxReady", 4'h0, rxReady);
      busyHigh = 0;
      rst = 1'b0;
      @(negedge clk);
      chk("busy", 4'h0, {3'h0, busy});
      repeat (60) @(negedge clk);
      chk("busyLen", 4'h0, 4'(busyHigh - OFFS));
      // Access while idle, then a refused one inside the pulse
      busyHigh = 0;
      reconfAccess = 1'b1;
      repeat (3) @(negedge clk);
      reconfAccess = 1'b0;
      repeat (2) @(negedge clk);
      reconfAccess = 1'b1;
      repeat (2) @(negedge clk);
      reconfAccess = 1'b0;
      repeat (40) @(negedge clk);
      chk("busyLen", 4'h0, 4'(busyHigh - serdes_seq_pkg::RECONF_BUSY_CYCLES - 1));
      // Enable low freezes the synchronisers: an access made then is lost
      busyHigh = 0;
      clkEn = 1'b0;
      reconfAccess = 1'b1;
      repeat (6) @(negedge clk);
      reconfAccess = 1'b0;
      repeat (2) @(negedge clk);
      clkEn = 1'b1;
      repeat (12) @(negedge clk);
      chk("busyFrozen", 4'h0, 4'(busyHigh));
      conclude();
   end
endmodule
